// [src/tpsc_pkg.sv]
// package: register map, field positions and scan constants for the power and scan config block
package tpsc_pkg;
  // ==========================================================================
  // register byte addresses (printed offsets are indices, byte address = 4 x index)
  localparam logic [7:0] CFG_INDEX = 8'h02;
  localparam logic [7:0] TARGET_INDEX = 8'h03;
  localparam logic [7:0] STATUS_INDEX = 8'h0A;
  localparam logic [7:0] READCH_INDEX = 8'h0B;
  localparam logic [7:0] THRESH_INDEX = 8'h10;
  localparam logic [11:0] CFG_ADDR = {2'h0, CFG_INDEX, 2'h0};
  localparam logic [11:0] TARGET_ADDR = {2'h0, TARGET_INDEX, 2'h0};
  localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};
  localparam logic [11:0] READCH_ADDR = {2'h0, READCH_INDEX, 2'h0};
  localparam logic [11:0] THRESH_ADDR = {2'h0, THRESH_INDEX, 2'h0};
  // ==========================================================================
  // configuration field positions
  localparam int SOFT_OFF_BIT = 15;
  localparam int HARD_OFF_BIT = 14;
  localparam int MONO_BIT = 13;
  localparam int VERBOSE_BIT = 11;
  localparam int LIMIT_BIT = 10;
  localparam int DIR_UP_BIT = 9;
  localparam int SCAN_BIT = 8;
  localparam int PWR_DIS_BIT = 6;
  localparam int PWR_EN_BIT = 0;
  // writable bits; reserved 12, 7 and 5..1 always read zero
  localparam logic [15:0] CFG_WMASK = 16'hEF41;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // status field positions
  localparam int DONE_BIT = 14;
  localparam int FAIL_BIT = 13;
  // ==========================================================================
  // channel range and scan timing
  localparam int TARGET_CHANNEL_SELECT_W = 10;
  localparam logic [9:0] TARGET_CHANNEL_SELECT_MIN = 10'h000;
  localparam logic [9:0] TARGET_CHANNEL_SELECT_MAX_DEF = 10'h0CC;
  localparam logic [7:0] THRESH_RESET = 8'h19;
  localparam logic [9:0] TARGET_RESET = 10'h000;
  localparam int DWELL_NS = 200;
  localparam int CLK_NS = 20;
  localparam int DWELL_CYC = (DWELL_NS + CLK_NS - 1) / CLK_NS;
  // scan engine states
  typedef enum logic [1:0] {SC_IDLE, SC_STEP, SC_DWELL, SC_DONE} tpsc_state_e;
endpackage

// [src/tpsc_scan_if.sv]
// interface: signals between register bank and scan stepper
`timescale 1ns/1ps
`default_nettype none
interface tpsc_scan_if;
  logic start;        // one-cycle scan start
  logic abort;        // scan request dropped
  logic dirUp;        // step upward
  logic stopAtEdge;   // stop at band edge
  logic [9:0] startChan; // channel to begin from
  logic [9:0] curChan;   // channel now tuned
  logic busy;         // scan running
  logic doneP;        // one-cycle finish pulse
  logic failP;        // finish without valid channel
  modport bank (output start, abort, dirUp, stopAtEdge, startChan,
                input curChan, busy, doneP, failP);
  modport scan (input start, abort, dirUp, stopAtEdge, startChan,
                output curChan, busy, doneP, failP);
endinterface
`default_nettype wire

// [src/tpsc_scan_step.sv]
// channel stepper that walks the band during a scan
`timescale 1ns/1ps
`default_nettype none
module tpsc_scan_step
  import tpsc_pkg::*;
#(
  parameter logic [9:0] TARGET_CHANNEL_SELECT_MAX = TARGET_CHANNEL_SELECT_MAX_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link to register bank
  tpsc_scan_if.scan sif,
  // signal quality of the channel now tuned
  input wire logic [7:0] rssi,
  input wire logic [7:0] threshold
);
  // ==========================================================================
  // state
  tpsc_state_e state_reg, state_next;
  logic [9:0] target_channel_select_reg, target_channel_select_next;      // current channel
  logic [9:0] origin_reg;               // where the scan began
  logic [7:0] dwell_reg;                // settle counter
  logic fail_reg, fail_next;
  // next channel, wrapping at either edge
  wire atTop = (target_channel_select_reg == TARGET_CHANNEL_SELECT_MAX);
  wire atBot = (target_channel_select_reg == TARGET_CHANNEL_SELECT_MIN);
  wire atEdge = sif.dirUp ? atTop : atBot;
  wire [9:0] wrapChan = sif.dirUp ? TARGET_CHANNEL_SELECT_MIN : TARGET_CHANNEL_SELECT_MAX;
  wire [9:0] stepChan = atEdge ? wrapChan :
    (sif.dirUp ? target_channel_select_reg + 10'h001 : target_channel_select_reg - 10'h001);
  wire qualified = (rssi >= threshold);
  wire dwellDone = (dwell_reg == 8'h00);

  // ==========================================================================
  // next-state logic
  always_comb begin
    state_next = state_reg;
    target_channel_select_next = target_channel_select_reg;
    fail_next = fail_reg;
    case (state_reg)
      SC_IDLE: begin
        if (sif.start) begin
          target_channel_select_next = sif.startChan;
          fail_next = 1'b0;
          state_next = SC_STEP;
        end
      end
      SC_STEP: begin
        if (sif.stopAtEdge && atEdge) begin
          fail_next = 1'b1;
          state_next = SC_DONE;
        end else begin
          target_channel_select_next = stepChan;
          state_next = SC_DWELL;
        end
      end
      SC_DWELL: begin
        if (dwellDone) begin
          if (qualified) begin
            state_next = SC_DONE;
          end else if (target_channel_select_reg == origin_reg) begin
            fail_next = 1'b1;
            state_next = SC_DONE;
          end else begin
            state_next = SC_STEP;
          end
        end
      end
      default: begin
        state_next = SC_IDLE;
      end
    endcase
    if (sif.abort && state_reg != SC_IDLE) begin
      state_next = SC_IDLE;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SC_IDLE;
      target_channel_select_reg <= TARGET_CHANNEL_SELECT_MIN;
      origin_reg <= TARGET_CHANNEL_SELECT_MIN;
      fail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      target_channel_select_reg <= target_channel_select_next;
      fail_reg <= fail_next;
      if (state_reg == SC_IDLE && sif.start) begin
        origin_reg <= sif.startChan;
      end
    end
  end

  // settle time before judging a channel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dwell_reg <= 8'h00;
    end else if (state_reg == SC_STEP) begin
      dwell_reg <= 8'(DWELL_CYC - 1);
    end else if (!dwellDone) begin
      dwell_reg <= dwell_reg - 8'h01;
    end
  end

  // outputs
  assign sif.curChan = target_channel_select_reg;
  assign sif.busy = (state_reg != SC_IDLE);
  assign sif.doneP = (state_reg == SC_DONE) && !sif.abort;
  assign sif.failP = fail_reg;
endmodule
`default_nettype wire

// [src/tpsc_power_seek_cfg.sv]
// top: APB register bank for power, audio and scan configuration
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tpsc_power_seek_cfg
  import tpsc_pkg::*;
#(
  parameter logic [9:0] TARGET_CHANNEL_SELECT_MAX = TARGET_CHANNEL_SELECT_MAX_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // signal quality from the receiver
  input wire logic [7:0] rssi,
  // audio and data-service controls
  output logic softAttenuationOff,
  output logic hardSilenceOff,
  output logic forceMono,
  output logic dataServiceVerboseSelect,
  // power sequencer requests
  output logic powerupEnable,
  output logic powerupDisable,
  output logic powerupWriteP
);
  // ==========================================================================
  // registers
  logic [15:0] cfg_reg;              // power and scan configuration
  logic [9:0] target_reg;            // host target channel
  logic [7:0] thresh_reg;            // scan validity threshold
  logic doneFlag_reg;                // operation complete flag
  logic failFlag_reg;                // scan fail or band limit flag
  logic startP_reg;                  // delayed scan start
  logic pwrP_reg;                    // power bits written
  logic [31:0] prdata_reg;           // read data

  tpsc_scan_if sif();

  // ==========================================================================
  // bus decode
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  wire hitCfg = (paddr == CFG_ADDR);
  wire hitTarget = (paddr == TARGET_ADDR);
  wire hitStatus = (paddr == STATUS_ADDR);
  wire hitReadch = (paddr == READCH_ADDR);
  wire hitThresh = (paddr == THRESH_ADDR);
  wire mapped = hitCfg || hitTarget || hitStatus || hitReadch || hitThresh;
  // reserved bits dropped whatever host writes
  wire [15:0] cfgWrite = pwdata[15:0] & CFG_WMASK;
  wire cfgWr = wrEn && hitCfg;
  wire scanReqNew = cfgWrite[SCAN_BIT];
  wire scanReqOld = cfg_reg[SCAN_BIT];
  // new scan only once both flags are clear
  wire flagsClear = !doneFlag_reg && !failFlag_reg;
  wire startScan = cfgWr && scanReqNew && !scanReqOld && flagsClear;

  // read mux
  wire [31:0] rdMux =
    hitCfg ? {16'h0000, cfg_reg} :
    hitTarget ? {22'h000000, target_reg} :
    // status exposes done at bit 14
    hitStatus ? {16'h0000, 1'b0, doneFlag_reg, failFlag_reg, 5'h00, rssi} :
    hitReadch ? {22'h000000, sif.curChan} :
    hitThresh ? {24'h000000, thresh_reg} : 32'h00000000;

  // ==========================================================================
  // configuration register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // power bits and all fields reset to zero
      cfg_reg <= CFG_RESET;
    end else if (cfgWr) begin
      cfg_reg <= cfgWrite;
    end
  end

  // target channel and threshold, untouched by scanning
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      target_reg <= TARGET_RESET;
      thresh_reg <= THRESH_RESET;
    end else begin
      // target only changes on host write
      if (wrEn && hitTarget) begin
        target_reg <= pwdata[9:0];
      end
      if (wrEn && hitThresh) begin
        thresh_reg <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // completion flags: the finish pulse is masked while the scan request is clear, so a clear in the same cycle wins
  wire clearFlags = !cfg_reg[SCAN_BIT];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      doneFlag_reg <= 1'b0;
      failFlag_reg <= 1'b0;
    end else if (sif.doneP) begin
      // done always, fail if nothing found
      doneFlag_reg <= 1'b1;
      failFlag_reg <= sif.failP;
    end else if (clearFlags) begin
      doneFlag_reg <= 1'b0;
      failFlag_reg <= 1'b0;
    end
  end

  // start and power pulses, bus read data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      startP_reg <= 1'b0;
      pwrP_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      startP_reg <= startScan;
      pwrP_reg <= cfgWr && (cfgWrite[PWR_EN_BIT] || cfgWrite[PWR_DIS_BIT]);
      if (rdEn) begin
        prdata_reg <= rdMux;
      end
    end
  end

  // ==========================================================================
  // scan stepper hookup
  // start from readback channel
  assign sif.start = startP_reg;
  assign sif.abort = !cfg_reg[SCAN_BIT];
  assign sif.dirUp = cfg_reg[DIR_UP_BIT];
  assign sif.stopAtEdge = cfg_reg[LIMIT_BIT];
  assign sif.startChan = sif.curChan;

  tpsc_scan_step #(
    .TARGET_CHANNEL_SELECT_MAX(TARGET_CHANNEL_SELECT_MAX)
  ) u_step (
    .clk(clk),
    .nrst(nrst),
    .sif(sif),
    .rssi(rssi),
    .threshold(thresh_reg)
  );

  // ==========================================================================
  // outputs
  // zero wait states keep the bus simple; reads come straight from the read mux during the access cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = rdEn ? rdMux : prdata_reg;
  assign softAttenuationOff = cfg_reg[SOFT_OFF_BIT];
  assign hardSilenceOff = cfg_reg[HARD_OFF_BIT];
  assign forceMono = cfg_reg[MONO_BIT];
  assign dataServiceVerboseSelect = cfg_reg[VERBOSE_BIT];
  assign powerupEnable = cfg_reg[PWR_EN_BIT];
  assign powerupDisable = cfg_reg[PWR_DIS_BIT];
  assign powerupWriteP = pwrP_reg;
endmodule
`default_nettype wire

// [dv/tpsc_power_seek_cfg_asserts.sv]
// checker: apb and control-output properties of the config block
`timescale 1ns/1ps
`default_nettype none
module tpsc_power_seek_cfg_asserts
  import tpsc_pkg::*;
#(
  parameter logic [9:0] TARGET_CHANNEL_SELECT_MAX = TARGET_CHANNEL_SELECT_MAX_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // controls driven by the block
  input wire logic softAttenuationOff,
  input wire logic hardSilenceOff,
  input wire logic forceMono,
  input wire logic dataServiceVerboseSelect,
  input wire logic powerupWriteP
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // access decode
  wire logic acc = psel && penable;
  wire logic wrCfg = acc && pwrite && (paddr == CFG_ADDR);
  wire logic mapped = (paddr == CFG_ADDR) || (paddr == TARGET_ADDR) ||
    (paddr == STATUS_ADDR) || (paddr == READCH_ADDR) || (paddr == THRESH_ADDR);
  wire logic [3:0] ctl = {softAttenuationOff, hardSilenceOff, forceMono, dataServiceVerboseSelect};
  // ==========================================================================
  // properties
  property p_soft; wrCfg |=> softAttenuationOff == $past(pwdata[15]); endproperty
  a_soft: assert property (p_soft) else $error("soft attenuation bit wrong");
  property p_hard; wrCfg |=> hardSilenceOff == $past(pwdata[14]); endproperty
  a_hard: assert property (p_hard) else $error("silence bit wrong");
  property p_mono; wrCfg |=> forceMono == $past(pwdata[13]); endproperty
  a_mono: assert property (p_mono) else $error("mono bit wrong");
  property p_verb; wrCfg |=> dataServiceVerboseSelect == $past(pwdata[11]); endproperty
  a_verb: assert property (p_verb) else $error("verbose bit wrong");
  // controls only move on a config write
  property p_hold; !wrCfg |=> $stable(ctl); endproperty
  a_hold: assert property (p_hold) else $error("control moved without write");
  property p_pwr; 1'b1 |-> powerupWriteP == $past(wrCfg && (pwdata[0] || pwdata[6])); endproperty
  a_pwr: assert property (p_pwr) else $error("power pulse wrong");
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_unmap; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_map; acc && mapped |-> !pslverr && prdata[31:16] == 16'h0; endproperty
  a_map: assert property (p_map) else $error("mapped access wrong");
  c_scan: cover property (wrCfg && pwdata[8]);
  c_pwr: cover property (powerupWriteP);
  c_err: cover property (acc && !mapped);
endmodule
bind tpsc_power_seek_cfg tpsc_power_seek_cfg_asserts #(.TARGET_CHANNEL_SELECT_MAX(TARGET_CHANNEL_SELECT_MAX)) u_chk (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .softAttenuationOff(softAttenuationOff), .hardSilenceOff(hardSilenceOff),
  .forceMono(forceMono), .dataServiceVerboseSelect(dataServiceVerboseSelect),
  .powerupWriteP(powerupWriteP));
`default_nettype wire

// [dv/tpsc_apb_host.sv]
// partner: host controller model driving the apb register port
`timescale 1ns/1ps
`default_nettype none
module tpsc_apb_host
  import tpsc_pkg::*;
(
  // clock
  input wire logic clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= (a == CFG_ADDR) ? (d & {16'h0, CFG_WMASK}) : d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/tpsc_power_seek_cfg_tb.sv]
// testbench: register, power and scan scenarios for the config block
`timescale 1ns/1ps
`default_nettype none
module tpsc_power_seek_cfg_tb
  import tpsc_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, pwp, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, q1;
  logic [7:0] rssi = 8'h00;
  logic [3:0] ctl; // soft, hard, mono, verbose
  logic [1:0] pwr; // enable, disable
  int n_fail = 0;
  int checked = 0;
  always #10 clk = ~clk;
  tpsc_power_seek_cfg u_tpsc_power_seek_cfg (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rssi(rssi), .softAttenuationOff(ctl[3]),
    .hardSilenceOff(ctl[2]), .forceMono(ctl[1]), .dataServiceVerboseSelect(ctl[0]),
    .powerupEnable(pwr[1]), .powerupDisable(pwr[0]), .powerupWriteP(pwp));
  tpsc_apb_host u_tpsc_apb_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_tpsc_apb_host.xfer(1'b1, a, d, rd, er);
    // outputs settle after the access edge; look at them half a cycle later
    @(negedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    u_tpsc_apb_host.xfer(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
  endtask
  task automatic flags(input logic [1:0] e);
    u_tpsc_apb_host.xfer(1'b0, STATUS_ADDR, 32'h0, rd, er);
    check({30'h0, rd[DONE_BIT], rd[FAIL_BIT]}, {30'h0, e});
  endtask
  // start a scan, poll for completion, judge, then clear the request
  task automatic scan(input logic [7:0] q, input logic [15:0] c, input logic [1:0] f,
                      input logic [9:0] ch);
    @(posedge clk) rssi <= q;
    wr(CFG_ADDR, {16'h0, c});
    for (int i = 0; i < 1500; i++) begin
      u_tpsc_apb_host.xfer(1'b0, STATUS_ADDR, 32'h0, rd, er);
      if (rd[DONE_BIT] === 1'b1) break;
    end
    flags(f);
    rdc(READCH_ADDR, {22'h0, ch});
    wr(CFG_ADDR, 32'h0);
    flags(2'b00);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    rdc(CFG_ADDR, 32'h0);
    rdc(THRESH_ADDR, 32'h19);
    check({26'h0, ctl, pwr}, 32'h0);
  endtask
  task automatic t_audio;
    wr(CFG_ADDR, 32'hA000);
    check({28'h0, ctl}, 32'hA);
    wr(CFG_ADDR, 32'h2800);
    check({28'h0, ctl}, 32'h3);
    rdc(CFG_ADDR, 32'h2800);
  endtask
  task automatic t_power;
    wr(CFG_ADDR, 32'h0041);
    check({30'h0, pwr}, 32'h3);
    check({31'h0, pwp}, 32'h1);
    wr(CFG_ADDR, 32'h0);
    u_tpsc_apb_host.xfer(1'b0, 12'h100, 32'h0, rd, er);
    check({rd[31:1], er}, 32'h1);
  endtask
  task automatic t_scans;
    wr(TARGET_ADDR, 32'h55);
    scan(8'h20, 16'h0300, 2'b10, 10'h001);
    rdc(TARGET_ADDR, 32'h55);
    scan(8'h00, 16'h0500, 2'b11, 10'h000);
    scan(8'h00, 16'h0100, 2'b11, 10'h000);
  endtask
  task automatic t_abort;
    wr(CFG_ADDR, 32'h0300);
    repeat (40) @(posedge clk);
    wr(CFG_ADDR, 32'h0);
    u_tpsc_apb_host.xfer(1'b0, READCH_ADDR, 32'h0, q1, er);
    check({31'h0, q1 != 32'h0}, 32'h1);
    repeat (50) @(posedge clk);
    rdc(READCH_ADDR, q1);
    flags(2'b00);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_audio;
    t_power;
    t_scans;
    t_abort;
    wrap_up;
  end
  // watchdog well beyond the longest scan lap
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
